/* File: hw/bbtc_pkg.sv */
// Purpose: Shared constants and types for the beam blanking teach control
// Assumes: 20 MHz clock, AHB-Lite register access
// Notes:   Beam count is a parameter of the top module; area limit is MAX_AREAS in this package
`default_nettype none
package bbtc_pkg;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_HZ          = 20000000;
  localparam int KEY_MIN_MS      = 150;
  localparam int KEY_MAX_MS      = 4000;
  localparam int SWITCH_MAX_MS   = 500;
  localparam int FLASH_MS        = 250;
  localparam int KEY_MIN_CYC     = (CLK_HZ / 1000) * KEY_MIN_MS;
  localparam int KEY_MAX_CYC     = (CLK_HZ / 1000) * KEY_MAX_MS;
  localparam int SWITCH_MAX_CYC  = (CLK_HZ / 1000) * SWITCH_MAX_MS;
  localparam int FLASH_CYC       = (CLK_HZ / 1000) * FLASH_MS;
  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] BEAMS_OFS  = 8'h08;
  localparam logic [7:0] TAUGHT_OFS = 8'h0C;
  localparam logic [7:0] AREAS_OFS  = 8'h10;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FG2_BIT   = 3;
  localparam int CTRL_RESOL     = 4;
  localparam int MAX_AREAS      = 10;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam logic [7:0] RESOL_RESET = 8'h02;
  typedef enum logic [1:0] {
    BBTC_ERR_NONE, BBTC_ERR_SIZE, BBTC_ERR_SYNC, BBTC_ERR_GAP
  } bbtc_err_type;
  typedef struct packed {
    logic [2:0] mode;
    logic       fg2;
    logic [7:0] resol;
  } bbtc_cfg_type;
endpackage : bbtc_pkg
`default_nettype wire

/* File: hw/bbtc_timer.sv */
// Purpose: Measures how long a level is held and flags the release window
// Assumes: level is already synchronised to clk
// Notes:   Counter saturates beyond the longest time
`default_nettype none
module bbtc_timer #(
  parameter int MIN_CYC = 3000000,
  parameter int MAX_CYC = 80000000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic level,
  output logic      good_release
);
  import bbtc_pkg::*;
  logic [26:0] cnt_reg;
  logic        lvl_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 27'h0;
      lvl_reg <= 1'b0;
    end else begin
      lvl_reg <= level;
      if (!level) begin
        cnt_reg <= 27'h0;
      end else if (cnt_reg <= 27'(MAX_CYC)) begin
        cnt_reg <= cnt_reg + 27'h1;
      end
    end
  end
  assign good_release = lvl_reg && !level && (cnt_reg >= 27'(MIN_CYC)) &&
                        (cnt_reg <= 27'(MAX_CYC));
endmodule : bbtc_timer
`default_nettype wire

/* File: hw/bbtc_top.sv */
// Purpose: Blanking and teach control of a light-curtain receiver
// Assumes: beams_blocked is a per-scan beam image, 1 = interrupted
// Notes:   Summary of operation
// Summary of operation
// - Outputs go off when active blanking misses its taught objects.
// - Up to ten fixed blanked areas of adjacent beams.
// - Configuration valid only if a synchronisation beam stays free.
// - Blanked areas must be separated by at least the resolution.
// - Modes 1, 2, 3 use fixed blanking without tolerance.
// - Modes 4 and 6 widen each fixed object by one beam each side.
// - Key release in 0.15 s to 4 s starts teach; indicator flashes.
// - Second valid key release ends teach and stores areas.
// - Indicator steady when areas taught and blanking switched on, off for free field.
// - Object size varying over one beam aborts teach with size error.
// - Floating blanking: ten areas, uniform object may move.
// - Mode 3 switches floating blanking via two-channel control.
// - Floating teach learns object size and movement range.
// - Floating blanking always brings reduced resolution along.
// - Modes 1 and 3 toggle blanking by antivalent inputs.
// - Valid switch sequence lights indicator and starts monitoring.
// - Reduced resolution tolerates small objects, no presence check.
// - Reduced resolution from mode 3 with function group two.
`default_nettype none
module bbtc_top #(
  parameter int BEAMS  = 32,
  parameter int KEY_MIN = bbtc_pkg::KEY_MIN_CYC,
  parameter int KEY_MAX = bbtc_pkg::KEY_MAX_CYC,
  parameter int SW_MAX  = bbtc_pkg::SWITCH_MAX_CYC,
  parameter int FLASH   = bbtc_pkg::FLASH_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [BEAMS-1:0] beams_blocked,
  input  wire logic             teach_key,
  input  wire logic             ctrl_in_a,
  input  wire logic             ctrl_in_b,
  output logic                  safety_switching_outputs,
  output logic                  blanking_indicator,
  output logic                  teach_size_error_message
);
  import bbtc_pkg::*;
  // ***************************************************
  // Synchronisers
  // ***************************************************
  logic [1:0] key_s, a_s, b_s;
  logic [BEAMS-1:0] bm1_reg, bm2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_s <= 2'h0;
      a_s <= 2'h0;
      b_s <= 2'h0;
      bm1_reg <= '0;
      bm2_reg <= '0;
    end else begin
      key_s <= {key_s[0], teach_key};
      a_s <= {a_s[0], ctrl_in_a};
      b_s <= {b_s[0], ctrl_in_b};
      bm1_reg <= beams_blocked;
      bm2_reg <= bm1_reg;
    end
  end
  wire logic key = key_s[1];
  wire logic ca = a_s[1];
  wire logic cb = b_s[1];
  wire logic [BEAMS-1:0] bm = bm2_reg;
  // ***************************************************
  // Register bus
  // ***************************************************
  bbtc_cfg_type cfg_reg;
  logic         ph_reg, pw_reg;
  logic [7:0]   pa_reg;
  logic [BEAMS-1:0] fixed_reg, float_reg;
  logic [3:0]   areas_reg;
  bbtc_err_type err_reg;
  logic         teach_reg, blank_on_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg <= 1'b0;
      pw_reg <= 1'b0;
      pa_reg <= 8'h00;
    end else if (hready) begin
      ph_reg <= hsel && htrans[1];
      pw_reg <= hwrite;
      pa_reg <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= '{mode: MODE_RESET, fg2: 1'b0, resol: RESOL_RESET};
    end else if (ph_reg && pw_reg && pa_reg == CTRL_OFS) begin
      cfg_reg.mode  <= hwdata[CTRL_MODE_LSB +: 3];
      cfg_reg.fg2   <= hwdata[CTRL_FG2_BIT];
      cfg_reg.resol <= hwdata[CTRL_RESOL +: 8];
    end
  end
  always_comb begin
    hrdata = 32'h0;
    case (pa_reg)
      CTRL_OFS:   hrdata = {20'h0, cfg_reg.resol, cfg_reg.fg2, cfg_reg.mode};
      STATUS_OFS: hrdata = {26'h0, blank_on_reg, teach_reg, err_reg,
                            safety_switching_outputs, blanking_indicator};
      BEAMS_OFS:  hrdata = 32'(bm);
      TAUGHT_OFS: hrdata = 32'(fixed_reg | float_reg);
      AREAS_OFS:  hrdata = {28'h0, areas_reg};
      default:    hrdata = 32'h0;
    endcase
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ***************************************************
  // Mode decode
  // ***************************************************
  wire logic tol_mode = cfg_reg.mode == 3'h4 || cfg_reg.mode == 3'h6;
  wire logic ctl_mode = cfg_reg.mode == 3'h1 || cfg_reg.mode == 3'h3;
  wire logic float_en = cfg_reg.mode == 3'h3 && blank_on_reg;
  wire logic reduce_en = (cfg_reg.mode == 3'h3 && cfg_reg.fg2)
                         || float_en;
  // ***************************************************
  // Teach key
  // ***************************************************
  logic key_ok;
  bbtc_timer #(.MIN_CYC(KEY_MIN), .MAX_CYC(KEY_MAX)) u_key (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .level        (key),
    .good_release (key_ok)
  );
  // ***************************************************
  // Teach session
  // ***************************************************
  logic [BEAMS-1:0] seen_reg, first_reg;
  logic [7:0]       size_reg;
  logic             size_val_reg;
  logic [7:0]       cur_size;
  always_comb begin
    cur_size = 8'h0;
    for (int i = 0; i < BEAMS; i++) cur_size = cur_size + 8'(bm[i]);
  end
  wire logic size_bad = size_val_reg && ((cur_size > size_reg + 8'h1) ||
                        (size_reg > cur_size + 8'h1));
  // Region analysis of a candidate image: area count, sync beams, gaps
  function automatic logic [3:0] count_areas(input logic [BEAMS-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < BEAMS; i++)
      if (v[i] && (i == 0 || !v[i-1])) n = n + 4'h1;
    return n;
  endfunction : count_areas
  function automatic logic gaps_ok(input logic [BEAMS-1:0] v,
                                   input logic [7:0] res);
    logic ok;
    int   gap;
    ok = 1'b1;
    gap = -1;
    for (int i = 0; i < BEAMS; i++) begin
      if (v[i]) begin
        if (gap > 0 && gap < int'(res)) ok = 1'b0;
        gap = 0;
      end else if (gap >= 0) begin
        gap = gap + 1;
      end
    end
    return ok;
  endfunction : gaps_ok
  wire logic [BEAMS-1:0] cand = seen_reg;
  wire logic [3:0] cand_n = count_areas(cand);
  wire logic sync_ok = !(cand[0] && cand[BEAMS-1]);
  wire logic gap_ok  = gaps_ok(cand, cfg_reg.resol);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      teach_reg <= 1'b0;
      seen_reg <= '0;
      first_reg <= '0;
      size_reg <= 8'h0;
      size_val_reg <= 1'b0;
      fixed_reg <= '0;
      float_reg <= '0;
      areas_reg <= 4'h0;
      err_reg <= BBTC_ERR_NONE;
    end else if (!teach_reg) begin
      if (key_ok) begin
        teach_reg <= 1'b1;
        seen_reg <= '0;
        first_reg <= bm;
        size_val_reg <= 1'b0;
        err_reg <= BBTC_ERR_NONE;
      end
    end else if (size_bad) begin
      teach_reg <= 1'b0;
      err_reg <= BBTC_ERR_SIZE;
    end else if (key_ok) begin
      teach_reg <= 1'b0;
      if (!sync_ok) begin
        err_reg <= BBTC_ERR_SYNC;
      end else if (!gap_ok || cand_n > 4'(MAX_AREAS)) begin
        err_reg <= BBTC_ERR_GAP;
      end else begin
        // Beams covered only by motion are floating, the rest fixed
        fixed_reg <= first_reg & bm;
        float_reg <= cand & ~(first_reg & bm);
        areas_reg <= cand_n;
      end
    end else begin
      seen_reg <= seen_reg | bm;
      if (cur_size != 8'h0) begin
        size_reg <= cur_size;
        size_val_reg <= 1'b1;
      end
    end
  end
  assign teach_size_error_message = err_reg == BBTC_ERR_SIZE;
  // ***************************************************
  // Antivalent control
  // ***************************************************
  logic [23:0] sw_cnt_reg;
  logic        sw_arm_reg, sw_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_cnt_reg <= 24'h0;
      sw_arm_reg <= 1'b0;
      sw_prev_reg <= 1'b0;
      blank_on_reg <= 1'b0;
    end else if (!ctl_mode) begin
      blank_on_reg <= 1'b1;
      sw_arm_reg <= 1'b0;
    end else if (ca != cb) begin
      // Arm on the first complementary level, time until both invert
      if (!sw_arm_reg) begin
        sw_arm_reg <= 1'b1;
        sw_prev_reg <= ca;
        sw_cnt_reg <= 24'h0;
      end else if (ca != sw_prev_reg) begin
        sw_prev_reg <= ca;
        sw_cnt_reg <= 24'h0;
        if (sw_cnt_reg < 24'(SW_MAX)) begin
          blank_on_reg <= !blank_on_reg;
        end
      end else if (sw_cnt_reg < 24'(SW_MAX)) begin
        sw_cnt_reg <= sw_cnt_reg + 24'h1;
      end
    end else begin
      // Equal levels end any sequence in progress
      sw_arm_reg <= 1'b0;
      sw_cnt_reg <= 24'h0;
    end
  end
  // ***************************************************
  // Monitoring and indicator
  // ***************************************************
  // Tolerance widening in modes 4 and 6; exact match otherwise
  wire logic [BEAMS-1:0] fix_win = tol_mode ?
    (fixed_reg | (fixed_reg << 1) | (fixed_reg >> 1)) : fixed_reg;
  // Tolerance modes accept the object shifted by one beam
  wire logic fix_exact = (fixed_reg & ~bm) == '0;
  wire logic fix_shift = ((fixed_reg << 1) & ~bm) == '0 ||
                         ((fixed_reg >> 1) & ~bm) == '0;
  wire logic fixed_present = fix_exact || (tol_mode && fix_shift);
  wire logic float_present = float_reg == '0 || (bm & float_reg) != '0;
  wire logic [BEAMS-1:0] outside = bm & ~fix_win & ~(float_en ? float_reg : '0);
  wire logic [7:0] out_cnt = count_ones(outside);
  function automatic logic [7:0] count_ones(input logic [BEAMS-1:0] v);
    logic [7:0] n;
    n = 8'h0;
    for (int i = 0; i < BEAMS; i++) n = n + 8'(v[i]);
    return n;
  endfunction : count_ones
  wire logic blank_act = blank_on_reg && (fixed_reg | float_reg) != '0;
  wire logic field_ok = reduce_en ? (out_cnt <= cfg_reg.resol)
                                  : (outside == '0);
  wire logic obj_ok = !blank_act ||
                      (fixed_present && (!float_en || float_present));
  logic [23:0] fl_cnt_reg;
  logic        fl_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fl_cnt_reg <= 24'h0;
      fl_reg <= 1'b0;
    end else if (fl_cnt_reg >= 24'(FLASH - 1)) begin
      fl_cnt_reg <= 24'h0;
      fl_reg <= !fl_reg;
    end else begin
      fl_cnt_reg <= fl_cnt_reg + 24'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safety_switching_outputs <= 1'b0;
      blanking_indicator <= 1'b0;
    end else begin
      safety_switching_outputs <= !teach_reg && field_ok && obj_ok;
      blanking_indicator <= teach_reg ? fl_reg :
                            blank_act;
    end
  end
  // ***************************************************
  // Checks
  // ***************************************************
  AST_OUT_OFF_MISSING: assert property (@(posedge hclk) disable iff (!hresetn)
    !obj_ok |=> !safety_switching_outputs)
    else $error("Outputs on while taught object missing");
  AST_TEACH_OUT_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    teach_reg |=> !safety_switching_outputs)
    else $error("Outputs on during teach");
  AST_TEACH_START: assert property (@(posedge hclk) disable iff (!hresetn)
    !teach_reg && key_ok |=> teach_reg)
    else $error("Teach did not start");
  AST_TEACH_END: assert property (@(posedge hclk) disable iff (!hresetn)
    teach_reg && key_ok |=> !teach_reg)
    else $error("Teach did not end");
  AST_NO_KEY_STAY: assert property (@(posedge hclk) disable iff (!hresetn)
    !key_ok && !size_bad |=> teach_reg == $past(teach_reg))
    else $error("Teach state changed without key");
  AST_SIZE_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
    teach_reg && size_bad |=> teach_size_error_message && !teach_reg)
    else $error("Size error not reported");
  AST_IND_STEADY: assert property (@(posedge hclk) disable iff (!hresetn)
    !teach_reg |=> blanking_indicator == $past(blank_act))
    else $error("Indicator wrong after teach");
  AST_SYNC_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    !(fixed_reg[0] || float_reg[0]) ||
    !(fixed_reg[BEAMS-1] || float_reg[BEAMS-1]))
    else $error("Both sync beams blanked");
  AST_NON_CTL_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctl_mode |=> blank_on_reg)
    else $error("Blanking off outside switchable modes");
endmodule : bbtc_top
`default_nettype wire

/* File: verif/bbtc_partner.sv */
// Purpose: Teach key switch and two-channel control source
// Assumes: changes land just after a rising clock edge
// Notes:   Both lines rest low between control sequences
`default_nettype none
module bbtc_partner (
  input  wire logic hclk,
  output logic      teach_key,
  output logic      ctrl_in_a,
  output logic      ctrl_in_b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    teach_key = 1'b0;
    ctrl_in_a = 1'b0;
    ctrl_in_b = 1'b0;
  end
  // ***************************************************
  // Key press held for n cycles, then released
  // ***************************************************
  task automatic press(input int n);
    @(posedge hclk);
    teach_key <= 1'b1;
    repeat (n) @(posedge hclk);
    teach_key <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : press
  // ***************************************************
  // Complementary levels, then both inverted after gap
  // ***************************************************
  task automatic switch_seq(input int gap);
    @(posedge hclk);
    ctrl_in_a <= 1'b1;
    ctrl_in_b <= 1'b0;
    repeat (gap) @(posedge hclk);
    ctrl_in_a <= 1'b0;
    ctrl_in_b <= 1'b1;
    repeat (10) @(posedge hclk);
    ctrl_in_b <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : switch_seq
endmodule : bbtc_partner
`default_nettype wire

/* File: verif/tb_beam_blanking_teach_control.sv */
// Purpose: Self-checking bench for the blanking teach control
// Assumes: short counts, key 10..100, switch 50, flash 4 cycles
// Notes:   Registers over AHB-Lite, keys and control via partner
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("CHECK FAILED %0t: got %h exp %h", $time, g, e); end end
module tb_beam_blanking_teach_control;
  timeunit 1ns;
  timeprecision 1ns;
  import bbtc_pkg::*;
  localparam int FL = 4;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] beams;
  logic [31:0] rd_cap;
  logic [31:0] v;
  logic        ind0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         outs;
  wire         ind;
  wire         szerr;
  wire         key;
  wire         ca;
  wire         cb;
  int          miscompares = 0;
  int          checked     = 0;
  int          cycles      = 0;

  bbtc_top #(.BEAMS(32), .KEY_MIN(10), .KEY_MAX(100), .SW_MAX(50),
    .FLASH(FL)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .beams_blocked(beams), .teach_key(key),
    .ctrl_in_a(ca), .ctrl_in_b(cb), .safety_switching_outputs(outs),
    .blanking_indicator(ind), .teach_size_error_message(szerr));
  bbtc_partner p (.hclk(hclk), .teach_key(key), .ctrl_in_a(ca),
    .ctrl_in_b(cb));

  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    rd_cap <= hrdata;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // ***************************************************
  // Bus and helper tasks
  // ***************************************************
  task automatic close_out();
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    #1 v = rd_cap;
  endtask : ahb
  task automatic rd(input logic [7:0] a);
    ahb({24'h0, a}, 1'b0, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb({24'h0, a}, 1'b1, d);
  endtask : wr
  task automatic set_beams(input logic [31:0] m);
    @(posedge hclk);
    beams <= m;
    repeat (6) @(posedge hclk);
  endtask : set_beams
  task automatic teach(input logic [31:0] m);
    set_beams(m);
    p.press(30);
    p.press(30);
    rd(STATUS_OFS);
  endtask : teach
  // ***************************************************
  // Test sequence
  // ***************************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    beams = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL_OFS);
    `CHK(v, 32'h0000_0021)
    rd(8'h40);
    `CHK(v, 32'h0)
    wr(STATUS_OFS, 32'hFFFF_FFFF);
    rd(STATUS_OFS);
    `CHK(v[4:2], 3'h0)
    p.press(3);
    p.press(150);
    rd(STATUS_OFS);
    `CHK(v[4], 1'b0)
    set_beams(32'h0000_0030);
    p.press(30);
    rd(STATUS_OFS);
    `CHK(v[4], 1'b1)
    @(negedge hclk);
    ind0 = ind;
    repeat (FL) @(negedge hclk);
    `CHK(ind, ~ind0)
    set_beams(32'h0000_00F0);
    repeat (4) @(posedge hclk);
    rd(STATUS_OFS);
    `CHK(v[4:2], 3'h1)
    `CHK(szerr, 1'b1)
    teach(32'h8000_0001);
    `CHK(v[3:2], 2'h2)
    teach(32'h0000_1B00);
    `CHK(v[3:2], 2'h3)
    teach(32'h9249_2492);
    `CHK(v[3:2], 2'h3)
    teach(32'h1249_2492);
    `CHK(v[3:2], 2'h0)
    rd(AREAS_OFS);
    `CHK(v, 32'd10)
    teach(32'h0);
    `CHK(ind, 1'b0)
    teach(32'h0000_0700);
    `CHK(v[4:0], 5'h02)
    rd(TAUGHT_OFS);
    `CHK(v, 32'h0000_0700)
    p.switch_seq(20);
    rd(STATUS_OFS);
    `CHK(v[5], 1'b1)
    `CHK(ind, 1'b1)
    `CHK(outs, 1'b1)
    set_beams(32'h0);
    `CHK(outs, 1'b0)
    p.switch_seq(80);
    rd(STATUS_OFS);
    `CHK(v[5], 1'b1)
    wr(CTRL_OFS, 32'h0000_0022);
    set_beams(32'h0000_0380);
    `CHK(outs, 1'b0)
    wr(CTRL_OFS, 32'h0000_0024);
    set_beams(32'h0000_0380);
    `CHK(outs, 1'b1)
    wr(CTRL_OFS, 32'h0000_002B);
    set_beams(32'h0030_0700);
    `CHK(outs, 1'b1)
    close_out();
  end
endmodule : tb_beam_blanking_teach_control
`undef CHK
`default_nettype wire
